// ===== logic/fistc_map.svh
`ifndef FISTC_MAP_SVH
`define FISTC_MAP_SVH
// Identification addresses
`define FISTC_ID_VENDOR_ADDR 16'hF000
`define FISTC_ID_FLASH_ADDR 16'hF001
`define FISTC_ID_PROT_ADDR 16'hFF7F
// Identification values, arbitrary neutral codes
`define FISTC_VENDOR_CODE 8'h5A
`define FISTC_FLASH_CODE 8'h3C
`define FISTC_PROT_OFF 8'hFF
`define FISTC_PROT_ON 8'h00
`define FISTC_ERASED 8'hFF
// Unlock pattern
`define FISTC_UNLOCK_A 12'h555
`define FISTC_UNLOCK_B 12'hAAA
`define FISTC_KEY_1 8'hAA
`define FISTC_KEY_2 8'h55
`define FISTC_CMD_PROG 8'hA0
`define FISTC_CMD_ERASE 8'h80
`define FISTC_CMD_ID 8'h90
`define FISTC_CMD_SEC 8'hA5
`define FISTC_CMD_EXIT 8'hF0
`define FISTC_CMD_CHIP 8'h10
`define FISTC_CMD_SECT 8'h30
// Control register fields and values
`define FISTC_MODE_ENABLE 3'b101
`define FISTC_MODE_DISABLE 3'b010
`define FISTC_COMMIT_KEY 8'hD5
`define FISTC_TOGGLE_BIT 6
// APB register offsets (controller side)
`define FISTC_REG_CTRL 12'h000
`define FISTC_REG_ADDR 12'h004
`define FISTC_REG_DATA 12'h008
`define FISTC_REG_STAT 12'h00C
// Timing at 50 MHz
`define FISTC_CLK_MHZ 50
`define FISTC_PROT_TIME_US 40
`define FISTC_PROG_TIME_US 40
`define FISTC_ERASE_TIME_MS 30
`define FISTC_PROT_CYCLES (`FISTC_PROT_TIME_US * `FISTC_CLK_MHZ)
`define FISTC_PROG_CYCLES (`FISTC_PROG_TIME_US * `FISTC_CLK_MHZ)
`define FISTC_ERASE_CYCLES (`FISTC_ERASE_TIME_MS * 1000 * `FISTC_CLK_MHZ)
`endif

// ===== logic/fistc_pkg.sv
package fistc_pkg;
  typedef enum logic [1:0] {
    fistc_op_none_type_v,
    fistc_op_prog_type_v,
    fistc_op_erase_type_v,
    fistc_op_prot_type_v
  } fistc_op_type;
endpackage : fistc_pkg

// ===== logic/fistc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fistc_if;
  logic req;
  logic we;
  logic wide;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic blocked;
  logic [2:0] command_exec_mode;
  logic [7:0] setting_commit_key;
  logic parallel_mode;
  logic serial_mode;
  modport device (input req, we, wide, addr, wdata, command_exec_mode, setting_commit_key,
    parallel_mode, serial_mode, output ack, rdata, blocked);
  modport host (output req, we, wide, addr, wdata, command_exec_mode, setting_commit_key,
    parallel_mode, serial_mode, input ack, rdata, blocked);
endinterface : fistc_if
`default_nettype wire

// ===== logic/fistc_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "fistc_map.svh"
// Summary of operation
// - ID entry maps vendor, flash, protection bytes
// - Protection byte all ones when off
// - ID exit returns to array reads
// - Protected parallel mode blocks array access
// - Protected serial mode refuses overwrite, loader
// - Only chip erase clears protection
// - Protection change within 40 us, busy
// - Busy reads invert bit six each time
// - First read after command shows one
// - Disabled mode stops toggle inversion
// - Poll toggle with byte reads only
// - Requester polls until two reads match
// - Slow reads see finished write, no toggle
// - Busy blocks all array reads and fetches
// - Byte access, 4k sector, chip erase
// - Reads single transfer, writes by sequence
// - No reset during busy operations
// - Enable: mode 101 then commit key
// - Disable: mode 010 then commit key
// - Erased bytes read all ones
// - Unlock upper nibble eight to fifteen
module fistc_device (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic serial_ldr_req, // Serial loader command request
  input wire logic serial_ovw_req, // Serial overwrite command request
  output logic serial_refused, // Serial command refused pulse
  output logic protected_out, // Protection state
  fistc_if.device bus // Requester side
);
  logic [7:0] mem [0:32767];
  logic [2:0] step;
  logic [2:0] next_step;
  logic enabled;
  logic prot;
  logic id_mode;
  logic toggle;
  logic [31:0] busy_cnt;
  fistc_pkg::fistc_op_type op;
  logic [15:0] op_addr;
  logic [7:0] op_data;
  logic [15:0] wipe_idx;
  logic wipe_all;
  logic busy;
  logic [2:0] mode_s1, mode_s2;
  logic [7:0] key_s1, key_s2;
  logic par_s1, par_s2, ser_s1, ser_s2;

  // Decode of the current bus request
  wire [11:0] low12 = bus.addr[11:0];
  wire upper_ok = bus.addr[15];
  wire wr = bus.req && bus.we;
  wire rd = bus.req && !bus.we;
  wire unlock_a = wr && upper_ok && low12 == `FISTC_UNLOCK_A;
  wire unlock_b = wr && upper_ok && low12 == `FISTC_UNLOCK_B;
  wire array_lock = prot && par_s2;
  wire go_seq = enabled && !busy;
  wire [14:0] idx = bus.addr[14:0];
  wire [7:0] id_byte = (bus.addr == `FISTC_ID_VENDOR_ADDR) ? `FISTC_VENDOR_CODE :
    (bus.addr == `FISTC_ID_FLASH_ADDR) ? `FISTC_FLASH_CODE :
    (bus.addr == `FISTC_ID_PROT_ADDR) ? (prot ? `FISTC_PROT_ON : `FISTC_PROT_OFF) :
    mem[idx];
  wire [7:0] status_byte = {1'b0, toggle, 6'b0};
  wire commit = key_s2 == `FISTC_COMMIT_KEY;

  // Command byte seen at the third cycle of an unlock sequence
  wire at_cmd = step == 3'd2 && unlock_a;
  wire cmd_id = at_cmd && bus.wdata == `FISTC_CMD_ID;
  wire cmd_sec = at_cmd && bus.wdata == `FISTC_CMD_SEC;
  wire cmd_prog = at_cmd && bus.wdata == `FISTC_CMD_PROG;
  // The exit byte needs no unlock and may go to any address
  wire cmd_exit = step == 3'd0 && bus.wdata == `FISTC_CMD_EXIT;
  wire erase_go = step == 3'd6 && (bus.wdata == `FISTC_CMD_CHIP ||
    bus.wdata == `FISTC_CMD_SECT);
  // Take each request once, on the cycle before the answer
  wire rd_take = rd && !bus.ack;
  wire seq_take = wr && !bus.ack && go_seq && !array_lock;
  wire count_done = busy_cnt <= 32'd1;

  // One unlock cycle: address low bits and data byte both match
  function automatic logic unlock_hit(input logic hit, input logic [7:0] d,
    input logic [7:0] key);
    unlock_hit = hit && d == key;
  endfunction : unlock_hit

  // Sequence step decode; any mismatch falls back to step 0
  always_comb begin
    next_step = 3'd0;
    unique case (step)
      3'd0: next_step = unlock_hit(unlock_a, bus.wdata, `FISTC_KEY_1) ? 3'd1 : 3'd0;
      3'd1: next_step = unlock_hit(unlock_b, bus.wdata, `FISTC_KEY_2) ? 3'd2 : 3'd0;
      3'd2: next_step = (unlock_a && (bus.wdata == `FISTC_CMD_PROG ||
        bus.wdata == `FISTC_CMD_SEC)) ? 3'd3 :
        (unlock_a && bus.wdata == `FISTC_CMD_ERASE) ? 3'd4 : 3'd0;
      3'd3: next_step = 3'd0;
      3'd4: next_step = unlock_hit(unlock_a, bus.wdata, `FISTC_KEY_1) ? 3'd5 : 3'd0;
      3'd5: next_step = unlock_hit(unlock_b, bus.wdata, `FISTC_KEY_2) ? 3'd6 : 3'd0;
      3'd6: next_step = 3'd0;
      default: next_step = 3'd0;
    endcase
  end

  // Control inputs come from another block: two stages first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s1 <= 3'd0;
      mode_s2 <= 3'd0;
      key_s1 <= 8'h00;
      key_s2 <= 8'h00;
      {par_s1, par_s2, ser_s1, ser_s2} <= 4'b0000;
    end else if (clk_en) begin
      mode_s1 <= bus.command_exec_mode;
      mode_s2 <= mode_s1;
      key_s1 <= bus.setting_commit_key;
      key_s2 <= key_s1;
      {par_s1, par_s2, ser_s1, ser_s2} <= {bus.parallel_mode, par_s1, bus.serial_mode, ser_s1};
    end
  end

  // Main sequencer; wipe_idx walks the array for erases, one byte a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step <= 3'd0;
      enabled <= 1'b0;
      prot <= 1'b0;
      id_mode <= 1'b0;
      toggle <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= 32'd0;
      op <= fistc_pkg::fistc_op_none_type_v;
      op_addr <= 16'h0000;
      op_data <= 8'h00;
      wipe_idx <= 16'h0000;
      wipe_all <= 1'b0;
      bus.ack <= 1'b0;
      bus.rdata <= 8'h00;
      bus.blocked <= 1'b0;
      serial_refused <= 1'b0;
      protected_out <= 1'b0;
    end else if (clk_en) begin
      bus.ack <= bus.req && !bus.ack;
      serial_refused <= prot && ser_s2 && (serial_ldr_req || serial_ovw_req);
      protected_out <= prot;
      bus.blocked <= busy || array_lock;
      if (commit && mode_s2 == `FISTC_MODE_ENABLE) enabled <= 1'b1;
      else if (commit && mode_s2 == `FISTC_MODE_DISABLE) enabled <= 1'b0;
      // Reads: status while busy, lock, ID bytes, or array data
      if (rd_take) begin
        if (busy) begin
          bus.rdata <= status_byte;
          if (enabled && !bus.wide) toggle <= ~toggle;
        end else if (array_lock) bus.rdata <= 8'h00;
        else if (id_mode) bus.rdata <= id_byte;
        else bus.rdata <= mem[idx];
      end
      // Writes advance the unlock sequence only when idle and enabled
      if (seq_take) begin
        step <= next_step;
        if (cmd_exit) id_mode <= 1'b0;
        if (cmd_id) id_mode <= 1'b1;
        if (cmd_sec) op <= fistc_pkg::fistc_op_prot_type_v;
        if (cmd_prog) op <= fistc_pkg::fistc_op_prog_type_v;
        if (step == 3'd3) begin
          busy <= 1'b1;
          toggle <= 1'b1;
          op_addr <= bus.addr;
          op_data <= bus.wdata;
          busy_cnt <= (op == fistc_pkg::fistc_op_prot_type_v) ? `FISTC_PROT_CYCLES : `FISTC_PROG_CYCLES;
        end
        if (erase_go) begin
          busy <= 1'b1;
          toggle <= 1'b1;
          op <= fistc_pkg::fistc_op_erase_type_v;
          wipe_all <= bus.wdata == `FISTC_CMD_CHIP;
          wipe_idx <= (bus.wdata == `FISTC_CMD_CHIP) ? 16'h0000 : {1'b0, bus.addr[14:12], 12'h000};
          busy_cnt <= `FISTC_ERASE_CYCLES;
        end
      end
      // Busy countdown; a program or protection change lands when the count expires
      if (busy) begin
        if (op == fistc_pkg::fistc_op_erase_type_v) begin
          mem[wipe_idx[14:0]] <= `FISTC_ERASED;
          if (wipe_idx[11:0] != 12'hFFF || (wipe_all && wipe_idx[14:12] != 3'd7))
            wipe_idx <= wipe_idx + 16'd1;
        end
        if (count_done) begin
          busy <= 1'b0;
          // Plain store: the array has no power-up value, and a byte is
          // programmed only once between erases, so no merge is needed
          if (op == fistc_pkg::fistc_op_prog_type_v) mem[op_addr[14:0]] <= op_data;
          if (op == fistc_pkg::fistc_op_prot_type_v) prot <= 1'b1;
          if (op == fistc_pkg::fistc_op_erase_type_v && wipe_all) prot <= 1'b0;
          op <= fistc_pkg::fistc_op_none_type_v;
        end else busy_cnt <= busy_cnt - 32'd1;
      end
    end
  end
endmodule : fistc_device
`default_nettype wire

// ===== logic/fistc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fistc_map.svh"
// Requester end: software drives it over APB
module fistc_host (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  fistc_if.host bus // Device side
);
  logic [31:0] ctrl;
  logic [15:0] addr_r;
  logic [7:0] data_r;
  logic pending;
  logic we_r;
  logic blk_s1, blk_s2;

  wire acc = psel && penable && !pready;
  wire sel_ctrl = paddr == `FISTC_REG_CTRL;
  wire sel_addr = paddr == `FISTC_REG_ADDR;
  wire sel_data = paddr == `FISTC_REG_DATA;
  wire sel_stat = paddr == `FISTC_REG_STAT;
  wire mapped = sel_ctrl || sel_addr || sel_data || sel_stat;
  // A data access waits for the device, others answer at once
  wire wait_dev = sel_data && !bus.ack;

  // Mode field and commit key go out as the software wrote them
  assign bus.command_exec_mode = ctrl[2:0];
  assign bus.setting_commit_key = ctrl[15:8];
  assign bus.parallel_mode = ctrl[16];
  assign bus.serial_mode = ctrl[17];
  assign bus.wide = 1'b0;
  assign bus.req = pending;
  assign bus.we = we_r;
  assign bus.addr = addr_r;
  assign bus.wdata = data_r;

  // APB slave; a data access becomes one byte transfer to the device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 32'h0000_0000;
      addr_r <= 16'hF000;
      data_r <= 8'h00;
      pending <= 1'b0;
      we_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
    end else if (clk_en) begin
      blk_s1 <= bus.blocked;
      blk_s2 <= blk_s1;
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (bus.ack) pending <= 1'b0;
      if (acc && sel_data && !pending && !bus.ack) begin
        pending <= 1'b1;
        we_r <= pwrite;
        if (pwrite) data_r <= pwdata[7:0];
      end
      if (acc && !(sel_data && !bus.ack)) begin
        pready <= 1'b1;
        pslverr <= !mapped;
        if (pwrite && sel_ctrl) ctrl <= pwdata;
        if (pwrite && sel_addr) addr_r <= pwdata[15:0];
        prdata <= sel_ctrl ? ctrl : sel_addr ? {16'h0000, addr_r} :
          sel_data ? {24'h00_0000, bus.rdata} : sel_stat ? {31'h0000_0000, blk_s2} :
          32'h0000_0000;
      end
    end
  end
endmodule : fistc_host
`default_nettype wire

// ===== verification/fistc_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the link between the requester end and the device end
module fistc_link_assertions (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic req, // Request
  input wire logic we, // Write
  input wire logic wide, // Wide transfer
  input wire logic [15:0] addr, // Address
  input wire logic [7:0] wdata, // Write byte
  input wire logic ack, // Answer pulse
  input wire logic [7:0] rdata, // Read byte
  input wire logic blocked, // Busy or array lock
  input wire logic [2:0] command_exec_mode // Mode field
);
  localparam int PROT_LIMIT = 2000;
  logic t_prev;
  logic t_have;
  logic [7:0] last_cmd;
  logic [15:0] busy_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Last read toggle bit and last command byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_prev <= 1'b0;
      t_have <= 1'b0;
      last_cmd <= 8'h00;
    end else begin
      if (ack && !we) begin
        t_prev <= rdata[6];
        t_have <= blocked;
      end
      if (req && we && ack && addr[11:0] == 12'h555) begin
        last_cmd <= wdata;
      end
    end
  end
  // Busy length, saturating so a long erase cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 16'h0000;
    end else if (!blocked) begin
      busy_cnt <= 16'h0000;
    end else if (busy_cnt != 16'hFFFF) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end
  end
  AST_ACK_AFTER_REQ: assert property (req && !ack |=> ack)
    else $error("device answer late");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
    else $error("request dropped before answer");
  AST_BYTE_ONLY: assert property (req |-> !wide)
    else $error("wide transfer issued");
  AST_RDATA_ON_READ: assert property ($changed(rdata) |-> ack && !we)
    else $error("read byte moved without read");
  AST_BUSY_MASK: assert property (ack && !we && blocked |-> (rdata & 8'hBF) == 8'h00)
    else $error("array data visible while busy");
  AST_TOGGLE_FLIPS: assert property (ack && !we && blocked && t_have
    && command_exec_mode == 3'b101 |-> rdata[6] != t_prev)
    else $error("toggle bit did not invert");
  AST_PROT_TIME: assert property (blocked && (last_cmd == 8'hA5 || last_cmd == 8'hA0)
    |-> busy_cnt <= PROT_LIMIT)
    else $error("operation busy too long");
  // Main scenarios reached
  cover property (ack && !we && blocked);
  cover property ($fell(blocked));
  cover property (ack && we);
endmodule : fistc_link_assertions
`default_nettype wire

// ===== verification/flash_id_security_toggle_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fistc_map.svh"
module flash_id_security_toggle_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, ldr, ovw, refused, prot;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] v, d, w;
  logic [7:0] mem [int];
  int fails, total_checks, cyc;
  fistc_if bus_if();
  fistc_host i_fistc_host (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus_if));
  fistc_device i_fistc_device (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .serial_ldr_req(ldr), .serial_ovw_req(ovw), .serial_refused(refused),
    .protected_out(prot), .bus(bus_if));
  fistc_link_assertions i_fistc_link_assertions (.pclk(pclk), .presetn(presetn),
    .req(bus_if.req), .we(bus_if.we), .wide(bus_if.wide), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata), .blocked(bus_if.blocked),
    .command_exec_mode(bus_if.command_exec_mode));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // One APB transfer, then one idle cycle so strobes never collide
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task fw(input logic [15:0] a, input logic [7:0] b);
    apb(1'b1, 12'h004, {16'h0000, a});
    apb(1'b1, 12'h008, {24'h00_0000, b});
  endtask : fw
  task fr(input logic [15:0] a);
    apb(1'b1, 12'h004, {16'h0000, a});
    apb(1'b0, 12'h008, 32'h0000_0000);
    v = q[7:0];
  endtask : fr
  task unlock(input logic [7:0] c);
    logic [3:0] h;
    h = 4'h8 + 4'($urandom_range(7));
    fw({h, 12'h555}, 8'hAA);
    fw({h, 12'hAAA}, 8'h55);
    fw({h, 12'h555}, c);
  endtask : unlock
  // Read twice until equal, as software polls
  task poll(input logic [15:0] a);
    int n;
    fr(a);
    chk(v[6], 1'b1);
    n = 0;
    do begin
      w = v;
      fr(a);
      n++;
      if (n == 1) chk(v[6], 1'b0);
    end while (v !== w && n < 600);
    chk(v, w);
  endtask : poll
  task ser(input logic o, input logic e);
    logic seen;
    ldr <= !o;
    ovw <= o;
    @(posedge pclk);
    ldr <= 1'b0;
    ovw <= 1'b0;
    seen = 1'b0;
    repeat (4) begin @(posedge pclk); seen = seen | refused; end
    chk(seen, e);
  endtask : ser
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, ldr, ovw} = 6'b00_0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    void'($urandom(92179));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(perr, 1'b1);
    chk(prot, 1'b0);
    apb(1'b1, 12'h000, 32'h0002_D505);
    ser(1'b0, 1'b0);
    ser(1'b1, 1'b0);
    $display("test reset done");
    d = 8'($urandom) | 8'h01;
    mem['h8123] = d;
    unlock(8'hA0);
    fw(16'h8123, d);
    unlock(8'hA0);
    fw(16'h8124, ~d);
    poll(16'h8123);
    chk(v, mem['h8123]);
    fr(16'h8124);
    chk(v === ~d, 1'b0);
    $display("test program done");
    unlock(8'hA0);
    fw(16'h8126, d);
    apb(1'b1, 12'h000, 32'h0002_D502);
    fr(16'h8126);
    w = v;
    fr(16'h8126);
    chk(v[6], w[6]);
    // Outlast the program, so the abort below meets an idle device
    repeat (250) fr(16'h8126);
    apb(1'b1, 12'h000, 32'h0002_D505);
    fw(16'hF555, 8'hAA);
    fw(16'hFAAA, 8'h00);
    fw(16'hF555, 8'hA0);
    fw(16'h8127, 8'h00);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(q[0], 1'b0);
    $display("test disable and abort done");
    unlock(8'h90);
    fr(`FISTC_ID_VENDOR_ADDR);
    chk(v, `FISTC_VENDOR_CODE);
    fr(`FISTC_ID_FLASH_ADDR);
    chk(v, `FISTC_FLASH_CODE);
    fr(16'hFF7F);
    chk(v, 8'hFF);
    fw(16'hF000, 8'hF0);
    fr(16'h8123);
    chk(v, mem['h8123]);
    $display("test identification done");
    unlock(8'hA5);
    fw(16'hFF7F, 8'h00);
    poll(16'hFF7F);
    chk(prot, 1'b1);
    unlock(8'h90);
    fr(16'hFF7F);
    chk(v === 8'hFF, 1'b0);
    fw(16'hF000, 8'hF0);
    ser(1'b0, 1'b1);
    ser(1'b1, 1'b1);
    chk(prot, 1'b1);
    // Parallel mode with protection on hides the array
    apb(1'b1, 12'h000, 32'h0001_D505);
    fr(16'h8123);
    chk(v, 8'h00);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(q[0], 1'b1);
    $display("test protection done");
    complete_run();
  end
endmodule : flash_id_security_toggle_ctrl_bench
`default_nettype wire
